/* dv/act_switch_model.sv */
/* Three half-bridge legs driven by the timer's complementary pairs.
   Assumes high and low gate drives are active high. */
`timescale 1ns/1ps
module act_switch_model
(
   // Clock and gate drives.
   input wire logic ref_clk,
   input wire logic [2:0] gate_hi,
   input wire logic [2:0] gate_lo,
   // Shoot-through and leg 0 low-side on-time counts.
   output int shoot_cnt,
   output int lo_cnt
);
   // A leg shorts the supply when both switches conduct.
   initial shoot_cnt = 0;
   initial lo_cnt = 0;
   always @(posedge ref_clk)
   begin
      if ((gate_hi & gate_lo) != 3'h0)
         shoot_cnt <= shoot_cnt + 1;
      lo_cnt <= lo_cnt + int'(gate_lo[0]);
   end
endmodule // act_switch_model

/* dv/act_timer_bench.sv */
/* Self-checking bench for the advanced-control timer.
   Assumes the design, checker and switch model are compiled first. */
`timescale 1ns/1ps
module act_timer_bench;
   // ****************************************************************
   // Stimulus and wiring
   // ****************************************************************
   logic ref_clk = 0, rstn = 0, enable = 0, link_trig_in = 0, link_start_sel = 0;
   logic dbg_halt = 0, dbg_freeze_en = 0, dbg_outs_off_en = 0, link_trig_out;
   logic [1:0] cnt_mode = 2'h0;
   logic [15:0] psc_div = 16'h0, period = 16'hA, count, c;
   logic [7:0] dead_time = 8'h2, ch_mode = 8'h9A;
   logic [63:0] ch_compare = 64'h0, ch_captured;
   logic [3:0] ch_capture_in = 4'h0, ch_out, dma_req;
   logic [2:0] ch_out_n;
   int error_cnt = 0, n_compared = 0, shoot_cnt, lo_cnt, n, hi, p, per, cmp, seen;
   always #2.5 ref_clk = ~ref_clk;
   act_timer i_act_timer (.ref_clk(ref_clk), .rstn(rstn), .enable(enable),
      .cnt_mode(cnt_mode), .psc_div(psc_div), .period(period), .dead_time(dead_time),
      .ch_mode(ch_mode), .ch_compare(ch_compare), .ch_capture_in(ch_capture_in),
      .ch_captured(ch_captured), .ch_out(ch_out), .ch_out_n(ch_out_n), .dma_req(dma_req),
      .count(count), .dbg_halt(dbg_halt), .dbg_freeze_en(dbg_freeze_en),
      .dbg_outs_off_en(dbg_outs_off_en), .link_trig_in(link_trig_in),
      .link_start_sel(link_start_sel), .link_trig_out(link_trig_out));
   act_switch_model i_act_switch_model (.ref_clk(ref_clk), .gate_hi(ch_out[2:0]),
      .gate_lo(ch_out_n), .shoot_cnt(shoot_cnt), .lo_cnt(lo_cnt));
   // Compares one result and counts it.
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (e !== g)
      begin
         error_cnt++;
         $display("BAD %s exp %0h got %0h", nm, e, g);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Restarts the counter with a new mode, prescale and top value.
   task automatic restart(logic [1:0] m, int ps, int pr);
      @(negedge ref_clk) enable = 0;
      repeat (3) @(negedge ref_clk);
      cnt_mode = m;
      psc_div = ps[15:0];
      period = pr[15:0];
      enable = 1;
   endtask
   // Counts cycles and channel 3 high cycles up to the next link trigger.
   task automatic to_trig();
      n = 0;
      hi = 0;
      do
      begin
         @(negedge ref_clk);
         n++;
         hi += int'(ch_out[3]);
      end while (link_trig_out !== 1'b1 && n < 9000);
   endtask
   // Waits a bounded time for a dma pulse on one channel.
   task automatic wait_dma(int ch);
      seen = 0;
      repeat (4000) @(negedge ref_clk) if (dma_req[ch] === 1'b1 && seen == 0) seen = 1;
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial
   begin
      #500000 error_cnt++;
      end_of_test();
   end
   initial
   begin
      void'($urandom(46027));
      repeat (4) @(negedge ref_clk);
      rstn = 1;
      chk("count after reset", 0, count);
      // Wrap spacing and duty in each direction, with off, random and full duty when counting up or down, and off duty only in up/down.
      for (int m = 0; m < 3; m++)
         for (int k = 0; k < 3; k++)
         begin
            p = $urandom_range(3, 0);
            per = $urandom_range(19, 4);
            cmp = (k == 0 || m == 2) ? 0 : (k == 1) ? $urandom_range(per, 1) : per + 1;
            ch_compare = {4{cmp[15:0]}};
            restart(m[1:0], p, per);
            to_trig();
            to_trig();
            chk("wrap cycles", (m == 2 ? per : per + 1) * (p + 1), n);
            chk("duty cycles", cmp * (p + 1), hi);
         end
      chk("low side used", 1, lo_cnt > 0);
      // Capture on channel 3 and compare match on channel 2.
      ch_mode = 8'h1A;
      ch_compare = {4{16'h0032}};
      restart(2'h0, 15, 200);
      wait_dma(2);
      chk("compare dma", 1, seen);
      @(count);
      @(negedge ref_clk) ch_capture_in = 4'h8;
      c = count;
      wait_dma(3);
      chk("capture dma", 1, seen);
      chk("captured", c, ch_captured[63:48]);
      ch_capture_in = 4'h0;
      // Debug halt freezes the counter and forces outputs off.
      ch_mode = 8'h9A;
      restart(2'h0, 0, 100);
      {dbg_halt, dbg_freeze_en, dbg_outs_off_en} = 3'h7;
      repeat (5) @(negedge ref_clk);
      c = count;
      repeat (10) @(negedge ref_clk);
      chk("frozen count", c, count);
      chk("outs off", 0, {ch_out, ch_out_n});
      dbg_halt = 0;
      repeat (5) @(negedge ref_clk);
      chk("count resumes", 1, count !== c);
      // A linked start waits for the trigger from another timer.
      link_start_sel = 1;
      restart(2'h0, 0, 100);
      repeat (10) @(negedge ref_clk);
      chk("held start", 0, count);
      link_trig_in = 1;
      @(negedge ref_clk) link_trig_in = 0;
      repeat (10) @(negedge ref_clk);
      chk("linked start", 1, count !== 16'h0);
      // One pulse on channel 3: live before the first wrap, silent after it.
      link_start_sel = 0;
      ch_mode = 8'hDA;
      ch_compare = {4{16'h0005}};
      restart(2'h0, 0, 20);
      to_trig();
      chk("one pulse seen", 1, hi > 0);
      to_trig();
      chk("one pulse done", 0, hi);
      chk("shoot-through", 0, shoot_cnt);
      end_of_test();
   end
endmodule // act_timer_bench

/* dv/act_timer_checker.sv */
/* Port assertions for the advanced-control timer.
   Assumes it is bound to act_timer with the default parameters. */
`timescale 1ns/1ps
module act_timer_checker
(
   // Clock, reset and controls.
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic enable,
   input wire logic [15:0] period,
   input wire logic dbg_halt,
   input wire logic dbg_freeze_en,
   input wire logic dbg_outs_off_en,
   // Timer outputs.
   input wire logic [3:0] ch_out,
   input wire logic [2:0] ch_out_n,
   input wire logic [3:0] dma_req,
   input wire logic [15:0] count,
   input wire logic link_trig_out
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // A debug halt is seen only after the two-flop synchroniser.
   sequence s_halt_off;
      (dbg_halt && dbg_outs_off_en)[*4];
   endsequence
   sequence s_halt_frz;
      (dbg_halt && dbg_freeze_en && enable)[*4];
   endsequence
   a_pair_no_overlap: assert property ((ch_out[2:0] & ch_out_n) == 3'h0)
      else $error("pair outputs active together");
   a_halt_outs_off: assert property (s_halt_off |-> ch_out == 4'h0 && ch_out_n == 3'h0)
      else $error("outputs live in halt");
   a_halt_count_frozen: assert property (s_halt_frz |=> $stable(count))
      else $error("count moved in halt");
   a_idle_count_zero: assert property (!enable [*3] |-> count == 16'h0)
      else $error("count not cleared when idle");
   a_count_one_step: assert property ($changed(count) && $past(enable) && enable |->
      (count - $past(count) == 16'h1) || ($past(count) - count == 16'h1) ||
      count == 16'h0 || count == period)
      else $error("count jumped");
   a_link_trig_pulse: assert property (link_trig_out |=> !link_trig_out)
      else $error("trigger longer than a cycle");
   a_dma_req_pulse: assert property ((dma_req & $past(dma_req)) == 4'h0)
      else $error("dma request longer than a cycle");
   a_reset_quiet: assert property (disable iff (1'b0) !rstn |=>
      count == 16'h0 && ch_out == 4'h0 && !link_trig_out)
      else $error("outputs live after reset");
endmodule // act_timer_checker

bind act_timer act_timer_checker i_act_timer_checker (.ref_clk(ref_clk), .rstn(rstn),
   .enable(enable), .period(period), .dbg_halt(dbg_halt), .dbg_freeze_en(dbg_freeze_en),
   .dbg_outs_off_en(dbg_outs_off_en), .ch_out(ch_out), .ch_out_n(ch_out_n),
   .dma_req(dma_req), .count(count), .link_trig_out(link_trig_out));

/* rtl/act_params.svh */
/*
 * Constants for the advanced-control timer: widths, channel counts and mode codes.
 * Assumes inclusion by bare name from the package and the timer module.
 */
`ifndef ACT_PARAMS_SVH
`define ACT_PARAMS_SVH

// ***********************************************************************
// Sizes
// ***********************************************************************
`define ACT_CNT_W 16
`define ACT_PSC_W 16
`define ACT_NCH 4
`define ACT_NCOMP 3
`define ACT_DT_W 8

// ***********************************************************************
// Counter direction modes
// ***********************************************************************
`define ACT_CNT_UP 2'h0
`define ACT_CNT_DOWN 2'h1
`define ACT_CNT_UPDN 2'h2

// ***********************************************************************
// Channel modes
// ***********************************************************************
`define ACT_CH_CAPTURE 2'h0
`define ACT_CH_COMPARE 2'h1
`define ACT_CH_PWM 2'h2
`define ACT_CH_ONEPULSE 2'h3

`endif

/* rtl/act_pkg.sv */
/*
 * Types shared by the advanced-control timer.
 * Assumes the constants header sits in the include path.
 */
`include "act_params.svh"

package act_pkg;

   // Counter run state, one-hot.
   typedef enum logic [2:0]
   {
      ACT_ST_IDLE = 3'h1,
      ACT_ST_RUN = 3'h2,
      ACT_ST_HALT = 3'h4
   } act_run_t;

endpackage

/* rtl/act_timer.sv */
/*
 * Advanced-control timer: prescaled 16-bit counter, four channels, dead-time pairs.
 * Assumes all control inputs are synchronous to ref_clk except capture inputs and
 * the debug halt, which are synchronised here.
 */
// Function
// - A 16-bit counter counts up, down, or alternately up and down.
// - The counter clock is the input clock divided by any factor from 1 to 65536.
// - DMA requests are raised and four channels exist, three with complementary outputs.
// - The timer serves as a three-phase PWM source over six outputs.
// - Complementary pairs get a programmable dead time between switching edges.
// - Each of the four channels independently does capture, compare, PWM or one-pulse.
// - PWM is edge- or centre-aligned with duty from fully off to fully on.
// - In debug halt the counter may stop and the PWM outputs may be forced off.
// - Trigger signals are exchanged with other timers for sync start and chaining.
`timescale 1ns/1ps
`include "act_params.svh"

module act_timer
#(
   parameter int CNT_W = `ACT_CNT_W,
   parameter int NCH = `ACT_NCH
)
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Counter control.
   input wire logic enable,
   input wire logic [1:0] cnt_mode,
   input wire logic [`ACT_PSC_W-1:0] psc_div,
   input wire logic [CNT_W-1:0] period,
   input wire logic [`ACT_DT_W-1:0] dead_time,
   // Channel control.
   input wire logic [2*NCH-1:0] ch_mode,
   input wire logic [CNT_W*NCH-1:0] ch_compare,
   input wire logic [NCH-1:0] ch_capture_in,
   output logic [CNT_W*NCH-1:0] ch_captured,
   // Outputs.
   output logic [NCH-1:0] ch_out,
   output logic [`ACT_NCOMP-1:0] ch_out_n,
   output logic [NCH-1:0] dma_req,
   output logic [CNT_W-1:0] count,
   // Debug.
   input wire logic dbg_halt,
   input wire logic dbg_freeze_en,
   input wire logic dbg_outs_off_en,
   // Timer link.
   input wire logic link_trig_in,
   input wire logic link_start_sel,
   output logic link_trig_out
);

   // ***********************************************************************
   // Synchronisers and run state
   // ***********************************************************************
   logic [NCH:0] sync_a;
   logic [NCH:0] sync_b;
   logic [NCH-1:0] cap_prev;
   logic halt;
   act_pkg::act_run_t run_st;
   logic [`ACT_PSC_W-1:0] psc_cnt;
   logic tick;
   logic dir_down;
   logic ovf;
   logic [NCH-1:0] pulse_done;

   // Two-flop synchronisers for debug halt and capture pins.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         sync_a <= '0;
         sync_b <= '0;
      end
      else
      begin
         sync_a <= {dbg_halt, ch_capture_in};
         sync_b <= sync_a;
      end
   end

   assign halt = sync_b[NCH];

   // Run state: starts on enable, or on a link trigger when selected.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         run_st <= act_pkg::ACT_ST_IDLE;
      else
      begin
         case (run_st)
            act_pkg::ACT_ST_IDLE:
               if (enable && (!link_start_sel || link_trig_in))
                  run_st <= act_pkg::ACT_ST_RUN;
            act_pkg::ACT_ST_RUN:
               if (!enable)
                  run_st <= act_pkg::ACT_ST_IDLE;
               else if (halt && dbg_freeze_en)
                  run_st <= act_pkg::ACT_ST_HALT;
            act_pkg::ACT_ST_HALT:
               if (!enable)
                  run_st <= act_pkg::ACT_ST_IDLE;
               else if (!halt)
                  run_st <= act_pkg::ACT_ST_RUN;
            default:
               run_st <= act_pkg::ACT_ST_IDLE;
         endcase
      end
   end

   // ***********************************************************************
   // Prescaler and counter
   // ***********************************************************************
   // Prescaler: a tick every psc_div+1 clocks, giving factors 1 to 65536.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn || run_st != act_pkg::ACT_ST_RUN)
         psc_cnt <= '0;
      else if (psc_cnt >= psc_div)
         psc_cnt <= '0;
      else
         psc_cnt <= psc_cnt + 1'b1;
   end

   assign tick = (run_st == act_pkg::ACT_ST_RUN) && (psc_cnt >= psc_div);

   // Counter with up, down and centre-aligned up/down modes.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn || run_st == act_pkg::ACT_ST_IDLE)
      begin
         count <= '0;
         dir_down <= 1'b0;
         ovf <= 1'b0;
      end
      else
      begin
         ovf <= 1'b0;
         if (tick)
         begin
            case (cnt_mode)
               `ACT_CNT_DOWN:
                  if (count == '0)
                  begin
                     count <= period;
                     ovf <= 1'b1;
                  end
                  else
                     count <= count - 1'b1;
               `ACT_CNT_UPDN:
                  if (!dir_down && count >= period)
                  begin
                     dir_down <= 1'b1;
                     count <= count - 1'b1;
                     ovf <= 1'b1;
                  end
                  else if (dir_down && count == '0)
                  begin
                     dir_down <= 1'b0;
                     count <= count + 1'b1;
                     ovf <= 1'b1;
                  end
                  else if (dir_down)
                     count <= count - 1'b1;
                  else
                     count <= count + 1'b1;
               default:
                  if (count >= period)
                  begin
                     count <= '0;
                     ovf <= 1'b1;
                  end
                  else
                     count <= count + 1'b1;
            endcase
         end
      end
   end

   // Update event goes out on the timer link for chaining.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         link_trig_out <= 1'b0;
      else
         link_trig_out <= ovf;
   end

   // ***********************************************************************
   // Channels
   // ***********************************************************************
   logic [NCH-1:0] ref_lvl;

   // Each channel works on its own mode, compare value and capture input.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         ref_lvl <= '0;
         cap_prev <= '0;
         ch_captured <= '0;
         dma_req <= '0;
         pulse_done <= '0;
      end
      else
      begin
         cap_prev <= sync_b[NCH-1:0];
         for (int i = 0; i < NCH; i++)
         begin
            dma_req[i] <= 1'b0;
            case (ch_mode[2*i +: 2])
               `ACT_CH_CAPTURE:
                  if (sync_b[i] && !cap_prev[i])
                  begin
                     ch_captured[CNT_W*i +: CNT_W] <= count;
                     dma_req[i] <= 1'b1;
                  end
               `ACT_CH_COMPARE:
                  if (tick && count == ch_compare[CNT_W*i +: CNT_W])
                  begin
                     ref_lvl[i] <= !ref_lvl[i];
                     dma_req[i] <= 1'b1;
                  end
               `ACT_CH_PWM:
                  // Compare 0 gives fully off, above period gives fully on.
                  ref_lvl[i] <= (count < ch_compare[CNT_W*i +: CNT_W]);
               default:
               begin
                  // One pulse: active below compare until the first overflow.
                  if (run_st == act_pkg::ACT_ST_IDLE)
                     pulse_done[i] <= 1'b0;
                  else if (ovf)
                     pulse_done[i] <= 1'b1;
                  ref_lvl[i] <= !pulse_done[i] && !ovf
                     && (count < ch_compare[CNT_W*i +: CNT_W]);
               end
            endcase
         end
      end
   end

   // ***********************************************************************
   // Dead-time insertion and output gating
   // ***********************************************************************
   logic [`ACT_NCOMP-1:0] ref_prev;
   logic [`ACT_DT_W*`ACT_NCOMP-1:0] dt_cnt;
   logic outs_off;

   assign outs_off = (run_st == act_pkg::ACT_ST_IDLE) || (halt && dbg_outs_off_en);

   // Pairs 0..2 form the three phases; both sides idle while dead time counts.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         ref_prev <= '0;
         dt_cnt <= '0;
         ch_out <= '0;
         ch_out_n <= '0;
      end
      else
      begin
         ref_prev <= ref_lvl[`ACT_NCOMP-1:0];
         for (int p = 0; p < `ACT_NCOMP; p++)
         begin
            if (ref_lvl[p] != ref_prev[p])
               dt_cnt[`ACT_DT_W*p +: `ACT_DT_W] <= dead_time;
            else if (dt_cnt[`ACT_DT_W*p +: `ACT_DT_W] != '0)
               dt_cnt[`ACT_DT_W*p +: `ACT_DT_W] <= dt_cnt[`ACT_DT_W*p +: `ACT_DT_W] - 1'b1;
            if (outs_off || ref_lvl[p] != ref_prev[p]
                || dt_cnt[`ACT_DT_W*p +: `ACT_DT_W] > `ACT_DT_W'(1))
            begin
               ch_out[p] <= 1'b0;
               ch_out_n[p] <= 1'b0;
            end
            else
            begin
               ch_out[p] <= ref_lvl[p];
               ch_out_n[p] <= !ref_lvl[p];
            end
         end
         ch_out[NCH-1] <= !outs_off && ref_lvl[NCH-1];
      end
   end

endmodule // act_timer
